// *** rtl/crf_pkg.sv ***
// Package for the CAN receive FIFO and identifier filter block
package crf_pkg;
   // Register word offsets (byte addresses)
   localparam logic [7:0] REG_CTRL_A    = 8'h00; // module_control_a
   localparam logic [7:0] REG_CTRL_B    = 8'h04; // module_control_b
   localparam logic [7:0] REG_TIMING_A  = 8'h08; // bit_timing_a
   localparam logic [7:0] REG_TIMING_B  = 8'h0c; // bit_timing_b
   localparam logic [7:0] REG_ACC_CTRL  = 8'h10; // id_accept_control
   localparam logic [7:0] REG_RX_FLAG   = 8'h14; // status and flags
   localparam logic [7:0] REG_ERR_CNT   = 8'h18; // error counters, read only
   localparam logic [7:0] REG_PATTERN0  = 8'h20; // id_accept_pattern 0..7
   localparam logic [7:0] REG_MASK0     = 8'h40; // id_accept_mask 0..7
   localparam logic [7:0] REG_FG_BASE   = 8'h80; // foreground_rx_buffer bytes 0..14
   // Control A bits
   localparam int CTLA_INIT_REQ  = 0;
   localparam int CTLA_POWERDOWN = 1;
   // Control B bits
   localparam int CTLB_ENABLE    = 7;
   localparam int CTLB_LOOPBACK  = 5;
   localparam int CTLB_INIT_ACK  = 0;
   // Flag register bits
   localparam int FLG_RX_FULL    = 0;
   localparam int FLG_OVERRUN    = 1;
   localparam int FLG_OVR_IE     = 2;
   localparam int FLG_RX_IE      = 3;
   // Geometry
   localparam int FIFO_DEPTH     = 5;
   localparam int BUF_BYTES      = 15;
   localparam int INIT_SYNC      = 3;
   // Filter mode encoding in id_accept_control[5:4]
   typedef enum logic [1:0] {CRF_MODE_32 = 2'h0, CRF_MODE_16 = 2'h1,
                             CRF_MODE_8 = 2'h2, CRF_MODE_CLOSED = 2'h3} crf_mode_t;
   typedef enum logic [1:0] {CRF_IDLE, CRF_RECV, CRF_DONE} crf_state_t;
endpackage

// *** rtl/crf_can_rx.sv ***
// CAN receive FIFO, acceptance filter and protection logic
// Operation
// - Five-entry queue; software sees oldest entry only; engine owns background buffer.
// - Every receive buffer holds fifteen bytes: identifier, control, data, stamp.
// - Receive-full flag is set exactly when foreground holds an accepted message.
// - Frame fills background while filtering; accepted frame pushes, flags, interrupts.
// - Ready for a new frame right after the previous interframe space.
// - Rejected or erroneous frames are not queued; background is overwritten.
// - Own transmitted frame captured but not queued, interrupted or acknowledged.
// - Loopback treats own frames like any other received frame.
// - After lost arbitration the winning frame goes through normal receive path.
// - Accepted frame with queue full is dropped; overrun interrupt if enabled.
// - Transmit keeps working while full; reception resumes once entry frees.
// - Identifier compared with pattern; set mask bits are don't care.
// - Three-bit hit index reports lowest matching filter.
// - 32-bit mode: two filters, bytes 0-3 and bytes 4-7.
// - 16-bit mode: four filters, two per four-byte bank.
// - 8-bit mode: eight filters on first identifier byte.
// - Closed mode never queues a frame nor sets receive-full.
// - Error counters cannot be changed by any register access.
// - Config registers writable only while init request and acknowledge set, or in special mode.
// - Transmit pin forced recessive in power-down or initialization mode.
// - Module enable accepts one write after reset in normal modes.
// - Init acknowledge set once the request has passed all three sync stages; receive state and queue are reset only after it.
`timescale 1ns/1ps
module crf_can_rx
   import crf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        resetn_in,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   // Receive engine byte stream
   input  wire logic        rx_start_in,
   input  wire logic        rx_byte_valid_in,
   input  wire logic [7:0]  rx_byte_in,
   input  wire logic        rx_end_ok_in,
   input  wire logic        rx_end_err_in,
   input  wire logic        rx_own_tx_in,
   input  wire logic        rx_arb_lost_in,
   // Status and system
   input  wire logic        special_mode_in,
   input  wire logic [7:0]  rx_err_count_in,
   input  wire logic [7:0]  tx_err_count_in,
   input  wire logic        tx_bit_in,
   output logic             bus_transmit_pin_out,
   output logic             ack_enable_out,
   output logic             rx_irq_out,
   output logic             err_irq_out
);
   logic [7:0] module_control_a, module_control_b, bit_timing_a, bit_timing_b;
   logic [7:0] id_accept_control;
   logic [7:0] id_accept_pattern [8];
   logic [7:0] id_accept_mask [8];
   logic [7:0] mem [DEPTH+1][BUF_BYTES];
   logic [2:0] hit_mem [DEPTH+1];
   logic [2:0] bg_slot, fg_slot, count;
   logic [3:0] byte_idx;
   logic       enable_written, rx_full_flag, overrun, rx_ie, ovr_ie;
   logic [INIT_SYNC-1:0] init_sync;
   logic       init_acknowledge;
   logic       own_frame;
   crf_state_t state;
   crf_mode_t  mode;
   logic       hit_any;
   logic [2:0] filter_hit_index;
   logic       cfg_open, wr, rd, clear_full, push, pop;
   logic [7:0] idb [4];
   logic       read_wait_done;
   logic [31:0] rdata;
   default clocking cb_main @(posedge sys_clk_in);
   endclocking
   default disable iff (!resetn_in);

   assign mode   = crf_mode_t'(id_accept_control[5:4]);
   assign wr     = avs_write_in;
   assign rd     = avs_read_in;
   assign avs_waitrequest_out = avs_read_in & ~read_wait_done;
   assign cfg_open = (module_control_a[CTLA_INIT_REQ] & init_acknowledge) | special_mode_in;
   assign clear_full = wr && avs_address_in == REG_RX_FLAG && avs_writedata_in[FLG_RX_FULL];

   // Reads take one wait state so that registered data stands at acceptance
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) read_wait_done <= 1'b0;
      else read_wait_done <= avs_read_in & ~read_wait_done;
   end

   // Initialization handshake passes through a short stage chain
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) init_sync <= '0;
      else init_sync <= {init_sync[INIT_SYNC-2:0], module_control_a[CTLA_INIT_REQ]};
   end
   assign init_acknowledge = &init_sync & module_control_a[CTLA_INIT_REQ];

   // Register writes; counters have no write path
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         module_control_a  <= 8'h01;
         module_control_b  <= 8'h00;
         bit_timing_a      <= 8'h00;
         bit_timing_b      <= 8'h00;
         id_accept_control <= 8'h00;
         enable_written    <= 1'b0;
         rx_ie <= 1'b0;
         ovr_ie <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            id_accept_pattern[i] <= 8'h00;
            id_accept_mask[i]    <= 8'h00;
         end
      end else if (wr) begin
         unique case (avs_address_in)
            REG_CTRL_A: module_control_a <= avs_writedata_in[7:0];
            REG_CTRL_B: begin
               if (!enable_written || special_mode_in) begin
                  module_control_b[CTLB_ENABLE] <= avs_writedata_in[CTLB_ENABLE];
                  enable_written <= 1'b1;
               end
               if (cfg_open)
                  module_control_b[6:1] <= avs_writedata_in[6:1];
            end
            REG_TIMING_A: if (cfg_open) bit_timing_a <= avs_writedata_in[7:0];
            REG_TIMING_B: if (cfg_open) bit_timing_b <= avs_writedata_in[7:0];
            REG_ACC_CTRL: if (cfg_open) id_accept_control[5:4] <= avs_writedata_in[5:4];
            REG_RX_FLAG: begin
               rx_ie  <= avs_writedata_in[FLG_RX_IE];
               ovr_ie <= avs_writedata_in[FLG_OVR_IE];
            end
            default: begin
               for (int i = 0; i < 8; i++) begin
                  if (cfg_open && avs_address_in == REG_PATTERN0 + 8'(4*i))
                     id_accept_pattern[i] <= avs_writedata_in[7:0];
                  if (cfg_open && avs_address_in == REG_MASK0 + 8'(4*i))
                     id_accept_mask[i] <= avs_writedata_in[7:0];
               end
            end
         endcase
      end
   end

   // Acceptance filter on first four identifier bytes as stored
   always_comb begin
      logic [7:0] m8;
      logic [15:0] m16;
      logic [31:0] m32;
      m8 = '0;
      m16 = '0;
      m32 = '0;
      hit_any = 1'b0;
      filter_hit_index = 3'h0;
      for (int b = 0; b < 4; b++) idb[b] = mem[bg_slot][b];
      for (int f = 7; f >= 0; f--) begin
         m8[f] = &(~(idb[0] ^ id_accept_pattern[(f/4)*4 + f%4]) | id_accept_mask[(f/4)*4 + f%4]);
      end
      for (int f = 3; f >= 0; f--) begin
         m16[f] = &(~({idb[0], idb[1]} ^ {id_accept_pattern[f*2], id_accept_pattern[f*2+1]})
                    | {id_accept_mask[f*2], id_accept_mask[f*2+1]});
      end
      for (int f = 1; f >= 0; f--) begin
         m32[f] = &(~({idb[0], idb[1], idb[2], idb[3]} ^ {id_accept_pattern[f*4],
                    id_accept_pattern[f*4+1], id_accept_pattern[f*4+2], id_accept_pattern[f*4+3]})
                    | {id_accept_mask[f*4], id_accept_mask[f*4+1], id_accept_mask[f*4+2],
                       id_accept_mask[f*4+3]});
      end
      unique case (mode)
         CRF_MODE_32: begin
            for (int f = 1; f >= 0; f--) begin
               if (m32[f]) begin
                  hit_any = 1'b1;
                  filter_hit_index = 3'(f);
               end
            end
         end
         CRF_MODE_16: begin
            for (int f = 3; f >= 0; f--) begin
               if (m16[f]) begin
                  hit_any = 1'b1;
                  filter_hit_index = 3'(f);
               end
            end
         end
         CRF_MODE_8: begin
            for (int f = 7; f >= 0; f--) begin
               if (m8[f]) begin
                  hit_any = 1'b1;
                  filter_hit_index = 3'(f);
               end
            end
         end
         CRF_MODE_CLOSED: hit_any = 1'b0;
      endcase
   end

   // Frame capture into background slot
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         state     <= CRF_IDLE;
         byte_idx  <= 4'h0;
         own_frame <= 1'b0;
      end else if (init_acknowledge) begin
         state <= CRF_IDLE;
      end else begin
         unique case (state)
            CRF_IDLE: if (rx_start_in) begin
               state     <= CRF_RECV;
               byte_idx  <= 4'h0;
               own_frame <= rx_own_tx_in;
            end
            CRF_RECV: begin
               if (rx_arb_lost_in) own_frame <= 1'b0;
               if (rx_byte_valid_in && byte_idx < 4'(BUF_BYTES)) begin
                  mem[bg_slot][byte_idx] <= rx_byte_in;
                  byte_idx <= byte_idx + 4'h1;
               end
               if (rx_end_ok_in || rx_end_err_in) state <= CRF_IDLE;
            end
            default: state <= CRF_IDLE;
         endcase
      end
   end

   // Push only accepted, error-free frames that are not own traffic unless loopback is set
   assign push = state == CRF_RECV && rx_end_ok_in && hit_any && count < 3'(DEPTH)
                 && (!own_frame || module_control_b[CTLB_LOOPBACK]);
   assign pop  = clear_full && rx_full_flag;

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in || init_acknowledge) begin
         bg_slot <= 3'h0;
         fg_slot <= 3'h0;
         count   <= 3'h0;
      end else begin
         if (push) begin
            hit_mem[bg_slot] <= filter_hit_index;
            bg_slot <= (bg_slot == 3'(DEPTH)) ? 3'h0 : bg_slot + 3'h1;
         end
         if (pop) fg_slot <= (fg_slot == 3'(DEPTH)) ? 3'h0 : fg_slot + 3'h1;
         count <= count + {2'h0, push} - {2'h0, pop};
      end
   end

   assign rx_full_flag = count != 3'h0;

   // Overrun: accepted frame with full queue; set wins over clear
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) overrun <= 1'b0;
      else if (state == CRF_RECV && rx_end_ok_in && hit_any && count == 3'(DEPTH)
               && (!own_frame || module_control_b[CTLB_LOOPBACK])) overrun <= 1'b1;
      else if (wr && avs_address_in == REG_RX_FLAG && avs_writedata_in[FLG_OVERRUN]) overrun <= 1'b0;
   end

   assign rx_irq_out  = rx_full_flag & rx_ie;
   assign err_irq_out = overrun & ovr_ie;
   assign ack_enable_out = state == CRF_RECV && !(own_frame && !module_control_b[CTLB_LOOPBACK]);
   // Transmit keeps running whatever the queue holds
   assign bus_transmit_pin_out = (module_control_a[CTLA_INIT_REQ] | module_control_a[CTLA_POWERDOWN])
                                 ? 1'b1 : tx_bit_in;

   always_comb begin
      rdata = 32'h0;
      unique case (avs_address_in)
         REG_CTRL_A:   rdata = {24'h0, module_control_a};
         REG_CTRL_B:   rdata = {24'h0, module_control_b[7:1], init_acknowledge};
         REG_TIMING_A: rdata = {24'h0, bit_timing_a};
         REG_TIMING_B: rdata = {24'h0, bit_timing_b};
         REG_ACC_CTRL: rdata = {24'h0, 2'h0, id_accept_control[5:4], 1'b0, hit_mem[fg_slot]};
         REG_RX_FLAG:  rdata = {28'h0, rx_ie, ovr_ie, overrun, rx_full_flag};
         REG_ERR_CNT:  rdata = {16'h0, tx_err_count_in, rx_err_count_in};
         default: begin
            for (int i = 0; i < 8; i++) begin
               if (avs_address_in == REG_PATTERN0 + 8'(4*i)) rdata = {24'h0, id_accept_pattern[i]};
               if (avs_address_in == REG_MASK0 + 8'(4*i)) rdata = {24'h0, id_accept_mask[i]};
            end
            for (int i = 0; i < BUF_BYTES; i++)
               if (avs_address_in == REG_FG_BASE + 8'(4*i)) rdata = {24'h0, mem[fg_slot][i]};
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) avs_readdata_out <= 32'h0;
      else if (rd && !read_wait_done) avs_readdata_out <= rdata;
   end

   // Named steps of the read handshake, the init handshake and a full-queue arrival
   sequence s_read_first;
      avs_read_in && !read_wait_done;
   endsequence
   sequence s_read_accept;
      avs_read_in && !avs_waitrequest_out;
   endsequence
   sequence s_init_rise;
      $rose(module_control_a[CTLA_INIT_REQ]);
   endsequence
   sequence s_full_arrival;
      state == CRF_RECV && rx_end_ok_in && hit_any && count == 3'(DEPTH)
         && (!own_frame || module_control_b[CTLB_LOOPBACK]);
   endsequence

   a_full_matches_count: assert property (
      push |=> rx_full_flag)
      else $error("push did not set full");
   a_closed_no_push: assert property (
      mode == CRF_MODE_CLOSED |-> !push)
      else $error("closed mode pushed");
   a_tx_recessive: assert property (
      module_control_a[CTLA_INIT_REQ] |-> bus_transmit_pin_out)
      else $error("tx not recessive");
   a_no_overfill: assert property (
      count == 3'(DEPTH) |-> !push)
      else $error("fifo overfilled");
   a_own_not_queued: assert property (
      own_frame && !module_control_b[CTLB_LOOPBACK] |-> !push)
      else $error("own frame queued");
   a_ack_after_init: assert property (
      s_init_rise |-> !init_acknowledge [*3])
      else $error("ack early");
   a_timing_locked: assert property (
      !cfg_open |=> $stable(bit_timing_a))
      else $error("timing changed while locked");
   a_error_no_push: assert property (
      !rx_end_ok_in |-> !push)
      else $error("push without good end");
   a_ack_arrives: assert property (
      s_init_rise ##1 module_control_a[CTLA_INIT_REQ] [*3] |-> init_acknowledge)
      else $error("init acknowledge late");
   a_init_flushes: assert property (
      init_acknowledge |=> count == 3'h0)
      else $error("queue kept entries in init");
   a_read_one_wait: assert property (
      s_read_first |-> avs_waitrequest_out)
      else $error("read accepted without wait state");
   a_read_data_ready: assert property (
      s_read_first ##1 s_read_accept |-> avs_readdata_out == $past(rdata))
      else $error("read data not standing at acceptance");
   a_write_no_wait: assert property (
      avs_write_in |-> !avs_waitrequest_out)
      else $error("write stalled");
   a_push_counts: assert property (
      push && !pop |=> count == $past(count) + 3'h1)
      else $error("push did not add an entry");
   a_pop_frees: assert property (
      pop && !push |=> count == $past(count) - 3'h1)
      else $error("clear did not release an entry");
   a_closed_stays_empty: assert property (
      mode == CRF_MODE_CLOSED && !rx_full_flag |=> !rx_full_flag)
      else $error("closed mode set full");
   a_reject_no_push: assert property (
      !hit_any |-> !push)
      else $error("rejected frame pushed");
   a_overrun_sets: assert property (
      s_full_arrival |=> overrun)
      else $error("overrun not flagged");
   a_tx_powerdown: assert property (
      module_control_a[CTLA_POWERDOWN] |-> bus_transmit_pin_out)
      else $error("tx not recessive in power-down");
   a_tx_follows_engine: assert property (
      !module_control_a[CTLA_INIT_REQ] && !module_control_a[CTLA_POWERDOWN]
         |-> bus_transmit_pin_out == tx_bit_in)
      else $error("tx pin not following engine");
   a_enable_once: assert property (
      enable_written && !special_mode_in |=> $stable(module_control_b[CTLB_ENABLE]))
      else $error("module enable rewritten");
   a_filter_locked: assert property (
      !cfg_open |=> $stable(id_accept_pattern[0]) && $stable(id_accept_mask[0])
         && $stable(id_accept_control))
      else $error("filter changed while locked");
   a_own_no_ack: assert property (
      own_frame && !module_control_b[CTLB_LOOPBACK] |-> !ack_enable_out)
      else $error("own frame acknowledged");
   a_hit_32_range: assert property (
      mode == CRF_MODE_32 |-> filter_hit_index <= 3'h1)
      else $error("hit index beyond two filters");
   a_counters_read: assert property (
      avs_read_in && !read_wait_done && avs_address_in == REG_ERR_CNT
         |=> avs_readdata_out == {16'h0, $past(tx_err_count_in), $past(rx_err_count_in)})
      else $error("error counters misread");
   a_lost_receives: assert property (
      state == CRF_RECV && rx_arb_lost_in |=> !own_frame)
      else $error("lost arbitration frame kept as own");
endmodule

// *** test/crf_node_model.sv ***
// Remote CAN node model feeding the receive engine byte stream
`timescale 1ns/1ps
module crf_node_model (
   // Clock
   input  wire logic       clk_in,
   // Receive engine stream
   output logic            start_out,
   output logic            valid_out,
   output logic [7:0]      byte_out,
   output logic            end_ok_out,
   output logic            end_err_out,
   output logic            own_out,
   output logic            lost_out
);
   int gap = 0;
   initial begin
      start_out = 1'b0;
      valid_out = 1'b0;
      byte_out = 8'h00;
      end_ok_out = 1'b0;
      end_err_out = 1'b0;
      own_out = 1'b0;
      lost_out = 1'b0;
   end
   // Frame of fifteen bytes; identifier bytes first, then tag plus byte index
   task automatic send(input logic [7:0] id, input logic [7:0] tag, input logic ok,
                       input logic own, input logic lost);
      start_out <= 1'b1;
      own_out <= own;
      @(posedge clk_in);
      start_out <= 1'b0;
      for (int k = 0; k < 15; k++) begin
         valid_out <= 1'b1;
         byte_out <= (k < 4) ? id : tag + 8'(k);
         lost_out <= lost && (k == 1);
         @(posedge clk_in);
         // Stale byte is inverted so a missed strobe cannot look correct
         if (gap > 0) begin
            valid_out <= 1'b0;
            lost_out <= 1'b0;
            byte_out <= ~byte_out;
            repeat (gap) @(posedge clk_in);
         end
      end
      valid_out <= 1'b0;
      lost_out <= 1'b0;
      end_ok_out <= ok;
      end_err_out <= ~ok;
      @(posedge clk_in);
      end_ok_out <= 1'b0;
      end_err_out <= 1'b0;
      own_out <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask
endmodule

// *** test/crf_can_rx_bench.sv ***
// Self-checking bench for the receive FIFO and identifier filter
`timescale 1ns/1ps
module crf_can_rx_bench import crf_pkg::*;;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic        rd_en = 1'b0;
   logic        wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        tx_bit = 1'b0;
   logic [31:0] rdata, d;
   logic        wait_req, pin, rx_irq, err_irq, ack_en;
   logic        f_start, f_valid, f_ok, f_err, f_own, f_lost;
   logic [7:0]  f_byte;
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          tt[4] = '{1, 2, 5, 0};
   int          ack_cnt = 0;
   always #2.5 clk = ~clk;
   // Counts frame bytes during which the block offers an acknowledge
   always @(posedge clk) if (f_valid && ack_en) ack_cnt <= ack_cnt + 1;
   crf_node_model node (.clk_in(clk), .start_out(f_start), .valid_out(f_valid),
      .byte_out(f_byte), .end_ok_out(f_ok), .end_err_out(f_err), .own_out(f_own),
      .lost_out(f_lost));
   crf_can_rx DUT (.sys_clk_in(clk), .resetn_in(rst_n), .avs_address_in(addr),
      .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .rx_start_in(f_start),
      .rx_byte_valid_in(f_valid), .rx_byte_in(f_byte), .rx_end_ok_in(f_ok),
      .rx_end_err_in(f_err), .rx_own_tx_in(f_own), .rx_arb_lost_in(f_lost),
      .special_mode_in(1'b0), .rx_err_count_in(8'h12), .tx_err_count_in(8'h34),
      .tx_bit_in(tx_bit), .bus_transmit_pin_out(pin), .ack_enable_out(ack_en),
      .rx_irq_out(rx_irq), .err_irq_out(err_irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      while (wait_req !== 1'b0) @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask
   // Read data is taken at the edge where waitrequest is seen low
   task automatic rd(input logic [7:0] a);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      while (wait_req !== 1'b0) @(posedge clk);
      d = rdata;
      rd_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic set_init(input logic on);
      d = {32{~on}};
      wr(REG_CTRL_A, {31'h0, on});
      for (int i = 0; i < 50 && d[CTLB_INIT_ACK] !== on; i++) rd(REG_CTRL_B);
      chk(32'(d[CTLB_INIT_ACK]), 32'(on));
      chk(32'(pin), 32'(on));
   endtask
   task automatic setup(input logic [1:0] m, input int t, input logic [7:0] cb);
      int w;
      w = (m == 2'h0) ? 4 : (m == 2'h1) ? 2 : 1;
      set_init(1'b1);
      wr(REG_CTRL_B, {24'h0, cb});
      wr(REG_ACC_CTRL, {26'h0, m, 4'h0});
      for (int i = 0; i < 8; i++) begin
         wr(REG_PATTERN0 + 8'(4 * i), (i / w < t) ? 32'ha5 : (i == w * t) ? 32'h55 : 32'h5a);
         wr(REG_MASK0 + 8'(4 * i), (i == w * t) ? 32'h0f : 32'h0);
      end
      rd(REG_PATTERN0 + 8'(4 * w * t));
      chk(d, 32'h55);
      set_init(1'b0);
   endtask
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      results();
   end
   initial begin
      int n;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(REG_CTRL_A);
      chk(d, 32'h1);
      // Mask-covered byte in each mode; extra match above the target filter in all but 32-bit mode
      for (int m = 0; m < 4; m++) begin
         setup(2'(m), tt[m], 8'h80);
         n = ack_cnt;
         node.send(8'h5a, 8'h00, 1'b1, 1'b1, 1'b0);
         chk(32'(ack_cnt - n), 32'h0);
         rd(REG_RX_FLAG);
         chk(d & 32'h1, 32'h0);
         n = ack_cnt;
         node.send(8'h5a, 8'h10, 1'b1, 1'b0, 1'b0);
         chk(32'(ack_cnt - n), 32'h0f);
         rd(REG_RX_FLAG);
         chk(d & 32'h1, 32'(m != 3));
         rd(REG_ACC_CTRL);
         if (m != 3) begin
            chk(d & 32'h7, 32'(tt[m]));
         end
      end
      setup(2'h2, 5, 8'h20);
      rd(REG_CTRL_B);
      chk(d & 32'ha0, 32'ha0);
      wr(REG_PATTERN0 + 8'h14, 32'h0);
      rd(REG_PATTERN0 + 8'h14);
      chk(d, 32'h55);
      wr(REG_CTRL_A, 32'h2);
      chk(32'(pin), 32'h1);
      wr(REG_CTRL_A, 32'h0);
      wr(REG_ERR_CNT, 32'h0);
      rd(REG_ERR_CNT);
      chk(d, 32'h3412);
      wr(REG_RX_FLAG, 32'h0c);
      node.send(8'h33, 8'h70, 1'b1, 1'b0, 1'b0);
      node.send(8'h5a, 8'h70, 1'b0, 1'b0, 1'b0);
      rd(REG_RX_FLAG);
      chk(d & 32'h3, 32'h0);
      node.gap = 2;
      node.send(8'h5a, 8'h10, 1'b1, 1'b0, 1'b0);
      node.gap = 0;
      node.send(8'h5a, 8'h20, 1'b1, 1'b1, 1'b0);
      node.send(8'h5a, 8'h30, 1'b1, 1'b1, 1'b1);
      node.send(8'h5a, 8'h40, 1'b1, 1'b0, 1'b0);
      node.send(8'h5a, 8'h50, 1'b1, 1'b0, 1'b0);
      chk(32'(err_irq), 32'h0);
      node.send(8'h5a, 8'h60, 1'b1, 1'b0, 1'b0);
      chk(32'(err_irq), 32'h1);
      tx_bit <= 1'b1;
      @(posedge clk);
      chk(32'(pin), 32'h1);
      tx_bit <= 1'b0;
      for (int k = 1; k < 6; k++) begin
         chk(32'(rx_irq), 32'h1);
         rd(REG_FG_BASE + 8'h10);
         chk(d, 32'(16 * k + 4));
         rd(REG_FG_BASE + 8'h38);
         chk(d, 32'(16 * k + 14));
         rd(REG_ACC_CTRL);
         chk(d & 32'h7, 32'h5);
         wr(REG_RX_FLAG, 32'h0d);
      end
      rd(REG_RX_FLAG);
      chk(d & 32'h3, 32'h2);
      chk(32'(rx_irq), 32'h0);
      wr(REG_RX_FLAG, 32'h0e);
      chk(32'(err_irq), 32'h0);
      node.send(8'h5a, 8'h70, 1'b1, 1'b0, 1'b0);
      rd(REG_FG_BASE + 8'h10);
      chk(d, 32'h74);
      results();
   end
endmodule
